// File: tmr_out_regs.sv
// timer output routing, upper byte registers and port output latch
//
// Notes on behaviour
// - 16-bit mode: field routes PWM to pins
// - split mode: bit0 puts upper PWM primary
// - split mode: bit1 puts lower PWM complement
// - field 00: both pins carry latch data
// - interrupt request only while local enable set
// - count upper byte RW, reset zero
// - reload upper byte RW, reset zero
// - capture/compare upper byte RW, reset zero
// - port latch resets to 1Fh
// - latch drives outputs, pull-ups on inputs
// - port read returns stored latch contents
// - direction change leaves latch unchanged
// - port latch bit 7 reads zero
// - mode bit 0 splits into 8-bit halves
// - polarity bit sets primary starting level
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module tmr_out_regs
    import tmr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pwm16_wave,
    input wire logic pwm8_upper_wave,
    input wire logic pwm8_lower_wave,
    input wire logic overflow_event,
    input wire logic capcomp_event,
    input wire logic count_upper_update,
    input wire logic [7:0] count_upper_live,
    input wire logic capcomp_upper_update,
    input wire logic [7:0] capcomp_upper_live,
    input wire logic [6:0] port_dir,
    output logic [7:0] timer_control_a,
    output logic split_counter_mode,
    output logic [7:0] count_upper_half,
    output logic count_upper_load,
    output logic [7:0] reload_upper_byte,
    output logic [7:0] capcomp_upper_byte,
    output logic capcomp_upper_load,
    output logic [6:0] port_pin_out,
    output logic [6:0] port_pin_oe,
    output logic [6:0] port_pullup_en,
    output logic timer_irq
);

    // ************************************************************
    // apb decode
    // ************************************************************
    logic [5:0] reg_idx;
    logic addr_aligned;
    logic idx_mapped;
    logic mapped;
    logic setup_rd;
    logic wr_en;
    logic wr_ctla;
    logic wr_count;
    logic wr_reload;
    logic wr_capc;
    logic wr_port;
    logic wr_mode;
    logic wr_status;
    logic wr_mask;

    assign reg_idx = paddr[7:2];
    assign addr_aligned = (paddr[1:0] == 2'h0);
    assign idx_mapped = (reg_idx <= TMR_IDX_IRQ_MASK);
    assign mapped = addr_aligned & idx_mapped;
    assign setup_rd = psel & ~penable & ~pwrite;
    // only the low byte lane carries register data
    assign wr_en = psel & penable & pwrite & mapped & pstrb[0];
    assign wr_ctla = wr_en & (reg_idx == TMR_IDX_CONTROL_A);
    assign wr_count = wr_en & (reg_idx == TMR_IDX_COUNT_UPPER);
    assign wr_reload = wr_en & (reg_idx == TMR_IDX_RELOAD_UPPER);
    assign wr_capc = wr_en & (reg_idx == TMR_IDX_CAPCOMP_UPPER);
    assign wr_port = wr_en & (reg_idx == TMR_IDX_PORT_LATCH);
    assign wr_mode = wr_en & (reg_idx == TMR_IDX_MODE);
    assign wr_status = wr_en & (reg_idx == TMR_IDX_IRQ_STATUS);
    assign wr_mask = wr_en & (reg_idx == TMR_IDX_IRQ_MASK);

    // zero wait states; read data is snapshotted in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] ctla_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic count_load_reg;
    logic [7:0] reload_reg;
    logic [7:0] capc_reg;
    logic [7:0] capc_next;
    logic capc_load_reg;
    logic [6:0] port_reg;
    logic [1:0] mode_reg;
    logic [1:0] mask_reg;
    logic pol_held_reg;
    logic oe0_prev_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // software load wins over an engine update in the same cycle
    assign count_next = wr_count ? pwdata[7:0] : (count_upper_update ? count_upper_live : count_reg);
    assign capc_next = wr_capc ? pwdata[7:0] : (capcomp_upper_update ? capcomp_upper_live : capc_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctla_reg <= TMR_CONTROL_A_RST;
            mode_reg <= TMR_MODE_RST;
            mask_reg <= TMR_IRQ_MASK_RST;
        end else begin
            if (wr_ctla) begin
                ctla_reg <= pwdata[7:0];
            end
            if (wr_mode) begin
                mode_reg <= pwdata[1:0];
            end
            if (wr_mask) begin
                mask_reg <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= TMR_BYTE_RST;
            reload_reg <= TMR_BYTE_RST;
            capc_reg <= TMR_BYTE_RST;
            count_load_reg <= 1'b0;
            capc_load_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            capc_reg <= capc_next;
            count_load_reg <= wr_count;
            capc_load_reg <= wr_capc;
            if (wr_reload) begin
                reload_reg <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_reg <= TMR_PORT_LATCH_RST;
        end else if (wr_port) begin
            port_reg <= pwdata[6:0];
        end
    end

    // ************************************************************
    // interrupt flags
    // ************************************************************
    tmr_evt_if ev_if[TMR_EVT_COUNT] ();
    logic [1:0] evt_in;
    logic [1:0] status_bits;

    assign evt_in[TMR_EVT_OVERFLOW_BIT] = overflow_event;
    assign evt_in[TMR_EVT_CAPCOMP_BIT] = capcomp_event;

    for (genvar g = 0; g < TMR_EVT_COUNT; g++) begin : g_evt
        assign ev_if[g].set = evt_in[g];
        assign ev_if[g].clr = wr_status & pwdata[g];
        assign status_bits[g] = ev_if[g].flag;
        tmr_evt_flag u_flag (
            .pclk(pclk),
            .presetn(presetn),
            .ev(ev_if[g])
        );
    end

    logic irq_local_en;
    assign irq_local_en = ctla_reg[TMR_CTLA_IRQ_EN_BIT];
    assign timer_irq = irq_local_en & (|(status_bits & mask_reg));

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        unique case (reg_idx)
            TMR_IDX_CONTROL_A: rd_byte = ctla_reg;
            TMR_IDX_COUNT_UPPER: rd_byte = count_reg;
            TMR_IDX_RELOAD_UPPER: rd_byte = reload_reg;
            TMR_IDX_CAPCOMP_UPPER: rd_byte = capc_reg;
            TMR_IDX_PORT_LATCH: rd_byte = {1'b0, port_reg};
            TMR_IDX_MODE: rd_byte = {6'h00, mode_reg};
            TMR_IDX_IRQ_STATUS: rd_byte = {6'h00, status_bits};
            TMR_IDX_IRQ_MASK: rd_byte = {6'h00, mask_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    assign prdata_next = (setup_rd & mapped) ? {24'h000000, rd_byte} : (setup_rd ? 32'h00000000 : prdata_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // ************************************************************
    // output routing
    // ************************************************************
    tmr_oe_e oe_field;
    logic split_mode;
    logic oe0;
    logic primary_on;
    logic complement_on;
    logic primary_wave;
    logic complement_wave;
    logic primary_pol_wave;

    assign oe0 = ctla_reg[TMR_CTLA_OE0_BIT];
    assign oe_field = tmr_oe_e'({mode_reg[TMR_MODE_OE1_BIT], oe0});
    assign split_mode = mode_reg[TMR_MODE_SPLIT_BIT];

    // polarity only reaches the pin when the output is switched on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_held_reg <= 1'b0;
            oe0_prev_reg <= 1'b0;
        end else begin
            oe0_prev_reg <= oe0;
            if (oe0 & ~oe0_prev_reg) begin
                pol_held_reg <= ctla_reg[TMR_CTLA_POL0_BIT];
            end
        end
    end

    assign primary_on = (oe_field == TMR_OE_PRIMARY) | (oe_field == TMR_OE_BOTH);
    assign complement_on = (oe_field == TMR_OE_COMPLEMENT) | (oe_field == TMR_OE_BOTH);
    assign primary_wave = split_mode ? pwm8_upper_wave : pwm16_wave;
    assign complement_wave = split_mode ? pwm8_lower_wave : pwm16_wave;
    assign primary_pol_wave = primary_wave ^ pol_held_reg;

    always_comb begin
        port_pin_out = port_reg;
        port_pin_oe = port_dir;
        if (primary_on) begin
            port_pin_out[TMR_PRIMARY_PIN_BIT] = primary_pol_wave;
            port_pin_oe[TMR_PRIMARY_PIN_BIT] = 1'b1;
        end
        if (complement_on) begin
            port_pin_out[TMR_COMPLEMENT_PIN_BIT] = complement_wave;
            port_pin_oe[TMR_COMPLEMENT_PIN_BIT] = 1'b1;
        end
    end

    // latch bits switch pull-ups on inputs
    assign port_pullup_en = ~port_pin_oe & port_reg;

    assign prdata = prdata_reg;
    assign timer_control_a = ctla_reg;
    assign split_counter_mode = split_mode;
    assign count_upper_half = count_reg;
    assign count_upper_load = count_load_reg;
    assign reload_upper_byte = reload_reg;
    assign capcomp_upper_byte = capc_reg;
    assign capcomp_upper_load = capc_load_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    irq_local_gate_a: assert property (timer_irq |-> ctla_reg[TMR_CTLA_IRQ_EN_BIT])
        else $error("interrupt raised without local enable");

    both_latch_a: assert property ((oe_field == TMR_OE_NONE) |-> (port_pin_out == port_reg))
        else $error("pins not on latch data with field 00");

    full_primary_a: assert property (!split_mode && oe_field == TMR_OE_PRIMARY
        |-> port_pin_out[TMR_PRIMARY_PIN_BIT] == (pwm16_wave ^ pol_held_reg)
        && port_pin_out[TMR_COMPLEMENT_PIN_BIT] == port_reg[TMR_COMPLEMENT_PIN_BIT])
        else $error("16-bit routing wrong");

    split_upper_a: assert property (split_mode && oe0
        |-> port_pin_out[TMR_PRIMARY_PIN_BIT] == (pwm8_upper_wave ^ pol_held_reg))
        else $error("primary pin not on upper half waveform");

    split_lower_a: assert property (split_mode && mode_reg[TMR_MODE_OE1_BIT]
        |-> port_pin_out[TMR_COMPLEMENT_PIN_BIT] == pwm8_lower_wave)
        else $error("complement pin not on lower half waveform");

    mode_switch_a: assert property (wr_mode && pwdata[0] && oe0 ##1 !wr_mode
        |-> port_pin_out[TMR_PRIMARY_PIN_BIT] == (pwm8_upper_wave ^ pol_held_reg))
        else $error("split mode did not select upper half");

    count_write_a: assert property (wr_count |=> count_upper_half == $past(pwdata[7:0]) && count_upper_load)
        else $error("count upper byte not loaded");

    reload_hold_a: assert property (wr_reload ##1 !wr_reload |-> reload_upper_byte == $past(pwdata[7:0], 1))
        else $error("reload upper byte not loaded");

    capc_write_a: assert property (wr_capc |=> capcomp_upper_byte == $past(pwdata[7:0]))
        else $error("capture/compare upper byte not loaded");

    port_read_a: assert property (setup_rd && reg_idx == TMR_IDX_PORT_LATCH && addr_aligned
        |=> prdata == {25'h0, port_reg})
        else $error("port read does not return latch");

    port_top_a: assert property (setup_rd && reg_idx == TMR_IDX_PORT_LATCH |=> prdata[31:7] == 25'h0)
        else $error("port latch bit 7 not zero");

    latch_stable_a: assert property (!wr_port |=> $stable(port_reg))
        else $error("latch changed without a write");

    pol_start_a: assert property ($rose(oe0) |=> pol_held_reg == $past(ctla_reg[TMR_CTLA_POL0_BIT]))
        else $error("polarity not taken at enable");

    pullup_a: assert property (!port_pin_oe[2] |-> port_pullup_en[2] == port_reg[2])
        else $error("pull-up not following latch bit");

    irq_seen_c: cover property (!timer_irq ##1 timer_irq);
    split_both_c: cover property (split_mode && oe_field == TMR_OE_BOTH);
    port_write_c: cover property (wr_port ##2 setup_rd && reg_idx == TMR_IDX_PORT_LATCH);
    bad_addr_c: cover property (pslverr);

endmodule

// File: tmr_pkg.sv
// constants for the timer output routing and byte register block
package tmr_pkg;

    // ************************************************************
    // register indices (byte address = 4 * index)
    // ************************************************************
    localparam logic [5:0] TMR_IDX_CONTROL_A = 6'h00;
    localparam logic [5:0] TMR_IDX_COUNT_UPPER = 6'h01;
    localparam logic [5:0] TMR_IDX_RELOAD_UPPER = 6'h02;
    localparam logic [5:0] TMR_IDX_CAPCOMP_UPPER = 6'h03;
    localparam logic [5:0] TMR_IDX_PORT_LATCH = 6'h04;
    localparam logic [5:0] TMR_IDX_MODE = 6'h05;
    localparam logic [5:0] TMR_IDX_IRQ_STATUS = 6'h06;
    localparam logic [5:0] TMR_IDX_IRQ_MASK = 6'h07;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int TMR_CTLA_IRQ_EN_BIT = 7;
    localparam int TMR_CTLA_OE0_BIT = 6;
    localparam int TMR_CTLA_POL0_BIT = 5;
    localparam int TMR_MODE_SPLIT_BIT = 0;
    localparam int TMR_MODE_OE1_BIT = 1;
    localparam int TMR_EVT_OVERFLOW_BIT = 0;
    localparam int TMR_EVT_CAPCOMP_BIT = 1;
    localparam int TMR_EVT_COUNT = 2;
    localparam int TMR_PORT_WIDTH = 7;
    localparam int TMR_PRIMARY_PIN_BIT = 0;
    localparam int TMR_COMPLEMENT_PIN_BIT = 1;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] TMR_CONTROL_A_RST = 8'h00;
    localparam logic [7:0] TMR_BYTE_RST = 8'h00;
    localparam logic [6:0] TMR_PORT_LATCH_RST = 7'h1F;
    localparam logic [1:0] TMR_MODE_RST = 2'h0;
    localparam logic [1:0] TMR_IRQ_MASK_RST = 2'h0;

    // ************************************************************
    // output enable field codes
    // ************************************************************
    typedef enum logic [1:0] {
        TMR_OE_NONE = 2'b00,
        TMR_OE_PRIMARY = 2'b01,
        TMR_OE_COMPLEMENT = 2'b10,
        TMR_OE_BOTH = 2'b11
    } tmr_oe_e;

endpackage

// File: tmr_evt_if.sv
// interface carrying one sticky event flag between its setter and owner
`timescale 1ns/1ps
interface tmr_evt_if;
    logic set;
    logic clr;
    logic flag;
    modport flag_side (input set, input clr, output flag);
    modport user_side (output set, output clr, input flag);
endinterface

// File: tmr_evt_flag.sv
// one sticky event flag, write-one-to-clear, set wins over clear
`timescale 1ns/1ps
module tmr_evt_flag
    import tmr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    tmr_evt_if.flag_side ev
);

    logic flag_reg;
    logic flag_next;

    // an event in the clearing cycle must not be lost
    assign flag_next = ev.set | (flag_reg & ~ev.clr);
    assign ev.flag = flag_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev.set |=> flag_reg)
        else $error("event flag missed a set");

endmodule

// File: tmr_out_regs_tb.sv
// self-checking testbench for the timer output routing and byte register block
`timescale 1ns/1ps
module tmr_out_regs_tb_top import tmr_pkg::*; ;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic w16 = 1'b0, wup = 1'b0, wlo = 1'b0, ev_ov = 1'b0, ev_cc = 1'b0, cu_upd = 1'b0, cc_upd = 1'b0;
    logic [7:0] cu_live = 8'h00, cc_live = 8'h00;
    logic [6:0] port_dir = 7'h00;
    logic [31:0] prdata;
    logic pready, pslverr, split_counter_mode, count_upper_load, capcomp_upper_load, timer_irq;
    logic [7:0] timer_control_a, count_upper_half, reload_upper_byte, capcomp_upper_byte;
    logic [6:0] port_pin_out, port_pin_oe, port_pullup_en;
    int error_cnt = 0;
    int n_checks = 0;

    always #50 pclk = ~pclk;

    tmr_out_regs tmr_out_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm16_wave(w16), .pwm8_upper_wave(wup), .pwm8_lower_wave(wlo),
        .overflow_event(ev_ov), .capcomp_event(ev_cc), .count_upper_update(cu_upd), .count_upper_live(cu_live),
        .capcomp_upper_update(cc_upd), .capcomp_upper_live(cc_live), .port_dir(port_dir),
        .timer_control_a(timer_control_a), .split_counter_mode(split_counter_mode),
        .count_upper_half(count_upper_half), .count_upper_load(count_upper_load),
        .reload_upper_byte(reload_upper_byte), .capcomp_upper_byte(capcomp_upper_byte),
        .capcomp_upper_load(capcomp_upper_load), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
        .port_pullup_en(port_pullup_en), .timer_irq(timer_irq));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic end_sim();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, idx, d, r, e);
    endtask

    task automatic rd_chk(input string name, input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        xfer(1'b0, idx, 8'h00, r, e);
        chk(name, {24'h00_0000, exp}, r);
        chk({name, " pslverr"}, 32'h0, {31'h0, e});
    endtask

    task automatic pulse(input logic capcomp);
        @(posedge pclk);
        ev_ov <= ~capcomp;
        ev_cc <= capcomp;
        @(posedge pclk);
        ev_ov <= 1'b0;
        ev_cc <= 1'b0;
        @(negedge pclk);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        rd_chk("control_a", TMR_IDX_CONTROL_A, 8'h00);
        rd_chk("count_upper", TMR_IDX_COUNT_UPPER, 8'h00);
        rd_chk("reload_upper", TMR_IDX_RELOAD_UPPER, 8'h00);
        rd_chk("capcomp_upper", TMR_IDX_CAPCOMP_UPPER, 8'h00);
        rd_chk("port_latch", TMR_IDX_PORT_LATCH, 8'h1F);
        rd_chk("irq_mask", TMR_IDX_IRQ_MASK, 8'h00);
    endtask

    task automatic t_bytes();
        wr(TMR_IDX_COUNT_UPPER, 8'hA5);
        // load strobe stands only in the cycle after the write edge
        @(negedge pclk);
        chk("count_upper_load", 32'h1, {31'h0, count_upper_load});
        wr(TMR_IDX_RELOAD_UPPER, 8'h5A);
        wr(TMR_IDX_CAPCOMP_UPPER, 8'hC3);
        @(negedge pclk);
        chk("capcomp_upper_load", 32'h1, {31'h0, capcomp_upper_load});
        chk("capcomp_upper_byte", 32'hC3, {24'h0, capcomp_upper_byte});
        rd_chk("count_upper", TMR_IDX_COUNT_UPPER, 8'hA5);
        rd_chk("reload_upper", TMR_IDX_RELOAD_UPPER, 8'h5A);
        rd_chk("capcomp_upper", TMR_IDX_CAPCOMP_UPPER, 8'hC3);
        chk("count_upper_half", 32'hA5, {24'h0, count_upper_half});
        chk("reload_upper_byte", 32'h5A, {24'h0, reload_upper_byte});
        @(posedge pclk);
        cu_upd <= 1'b1;
        cu_live <= 8'h3C;
        cc_upd <= 1'b1;
        cc_live <= 8'h96;
        @(posedge pclk);
        cu_upd <= 1'b0;
        cc_upd <= 1'b0;
        @(negedge pclk);
        chk("count_upper_load engine", 32'h0, {31'h0, count_upper_load});
        chk("capcomp_upper_load engine", 32'h0, {31'h0, capcomp_upper_load});
        rd_chk("count_upper live", TMR_IDX_COUNT_UPPER, 8'h3C);
        rd_chk("capcomp_upper live", TMR_IDX_CAPCOMP_UPPER, 8'h96);
    endtask

    task automatic t_port();
        wr(TMR_IDX_PORT_LATCH, 8'hFF);
        rd_chk("port_latch bit7", TMR_IDX_PORT_LATCH, 8'h7F);
        @(posedge pclk);
        port_dir <= 7'h0F;
        @(negedge pclk);
        chk("port_pin_out", 32'h7F, {25'h0, port_pin_out});
        chk("port_pullup_en", 32'h70, {25'h0, port_pullup_en});
        rd_chk("port_latch after dir", TMR_IDX_PORT_LATCH, 8'h7F);
        wr(TMR_IDX_PORT_LATCH, 8'h2A);
        @(negedge pclk);
        chk("port_pullup_en", 32'h20, {25'h0, port_pullup_en});
        rd_chk("port_latch", TMR_IDX_PORT_LATCH, 8'h2A);
        @(posedge pclk);
        port_dir <= 7'h00;
    endtask

    // polarity stays 0 here, so routed pins show the raw wave
    task automatic t_mux();
        logic [1:0] o;
        logic [2:0] w;
        logic ep, ec;
        for (int m = 0; m < 2; m++) begin
            wr(TMR_IDX_PORT_LATCH, m ? 8'h03 : 8'h00);
            for (int oe = 0; oe < 4; oe++) begin
                o = oe[1:0];
                wr(TMR_IDX_CONTROL_A, {1'b0, o[0], 6'h00});
                wr(TMR_IDX_MODE, {6'h00, o[1], m[0]});
                for (int k = 0; k < 8; k++) begin
                    w = k[2:0];
                    @(posedge pclk);
                    {w16, wup, wlo} <= w;
                    @(negedge pclk);
                    ep = o[0] ? (m ? w[1] : w[2]) : m[0];
                    ec = o[1] ? (m ? w[0] : w[2]) : m[0];
                    chk("primary pin", {31'h0, ep}, {31'h0, port_pin_out[0]});
                    chk("complement pin", {31'h0, ec}, {31'h0, port_pin_out[1]});
                    chk("pin oe", {30'h0, o}, {30'h0, port_pin_oe[1:0]});
                end
                chk("split mode", {31'h0, m[0]}, {31'h0, split_counter_mode});
            end
        end
    endtask

    task automatic t_pol();
        wr(TMR_IDX_MODE, 8'h00);
        wr(TMR_IDX_CONTROL_A, 8'h20);
        wr(TMR_IDX_CONTROL_A, 8'h60);
        @(posedge pclk);
        w16 <= 1'b0;
        @(negedge pclk);
        chk("primary start high", 32'h1, {31'h0, port_pin_out[0]});
        @(posedge pclk);
        w16 <= 1'b1;
        @(negedge pclk);
        chk("primary inverted", 32'h0, {31'h0, port_pin_out[0]});
        chk("timer_control_a", 32'h60, {24'h0, timer_control_a});
    endtask

    task automatic t_irq();
        wr(TMR_IDX_IRQ_MASK, 8'h03);
        wr(TMR_IDX_CONTROL_A, 8'h00);
        pulse(1'b0);
        chk("irq local disabled", 32'h0, {31'h0, timer_irq});
        rd_chk("irq_status", TMR_IDX_IRQ_STATUS, 8'h01);
        wr(TMR_IDX_CONTROL_A, 8'h80);
        @(negedge pclk);
        chk("irq enabled", 32'h1, {31'h0, timer_irq});
        wr(TMR_IDX_IRQ_MASK, 8'h00);
        @(negedge pclk);
        chk("irq masked", 32'h0, {31'h0, timer_irq});
        wr(TMR_IDX_IRQ_MASK, 8'h03);
        wr(TMR_IDX_IRQ_STATUS, 8'h01);
        @(negedge pclk);
        chk("irq cleared", 32'h0, {31'h0, timer_irq});
        pulse(1'b1);
        chk("irq capcomp", 32'h1, {31'h0, timer_irq});
        rd_chk("irq_status", TMR_IDX_IRQ_STATUS, 8'h02);
        wr(TMR_IDX_IRQ_STATUS, 8'h02);
        rd_chk("irq_status cleared", TMR_IDX_IRQ_STATUS, 8'h00);
    endtask

    task automatic t_err();
        logic [31:0] r;
        logic e;
        xfer(1'b0, 6'h08, 8'h00, r, e);
        chk("unmapped pslverr", 32'h1, {31'h0, e});
        chk("unmapped prdata", 32'h0, r);
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_bytes();
        t_port();
        t_mux();
        t_pol();
        t_irq();
        t_err();
        end_sim();
    end

    // whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end
endmodule
